// >>> hw/ebt_pkg.sv
// package: register map, field layout and timing constants for the 8-bit wrap timer
package ebt_pkg;

    localparam int unsigned EBT_ADDR_W = 12;
    localparam int unsigned EBT_DATA_W = 32;
    localparam int unsigned EBT_CNT_W = 8;
    localparam int unsigned EBT_SEL_W = 3;

    // register byte offsets
    localparam logic [11:0] EBT_OFS_CONTROL = 12'h000;
    localparam logic [11:0] EBT_OFS_COUNT = 12'h004;
    localparam logic [11:0] EBT_OFS_IRQ_MASK = 12'h008;
    localparam logic [11:0] EBT_OFS_IRQ_FLAGS = 12'h00c;
    localparam logic [11:0] EBT_OFS_IRQ_STATUS = 12'h010;
    localparam logic [11:0] EBT_OFS_GLOBAL = 12'h014;

    // field positions
    localparam int unsigned EBT_SEL_LSB = 0;
    localparam int unsigned EBT_WRAP_BIT = 0;
    localparam int unsigned EBT_GIE_BIT = 0;
    localparam int unsigned EBT_ACK_BIT = 1;

    // reset values and count constants
    localparam logic [7:0] EBT_CNT_RST = 8'h00;
    localparam logic [2:0] EBT_SEL_RST = 3'h0;
    localparam logic [7:0] EBT_CNT_ONE = 8'h01;
    localparam logic [7:0] EBT_CNT_MAX = 8'hff;

    // prescaler divisors and width
    localparam int unsigned EBT_DIV_A = 8;
    localparam int unsigned EBT_DIV_B = 64;
    localparam int unsigned EBT_DIV_C = 256;
    localparam int unsigned EBT_DIV_D = 1024;
    localparam int unsigned EBT_PRE_W = 10;

    typedef enum logic [2:0] {
        EBT_SRC_STOP = 3'h0,
        EBT_SRC_DIRECT = 3'h1,
        EBT_SRC_DIV8 = 3'h2,
        EBT_SRC_DIV64 = 3'h3,
        EBT_SRC_DIV256 = 3'h4,
        EBT_SRC_DIV1024 = 3'h5,
        EBT_SRC_PIN_FALL = 3'h6,
        EBT_SRC_PIN_RISE = 3'h7
    } ebt_src_e;

    typedef struct packed {
        logic div8;
        logic div64;
        logic div256;
        logic div1024;
    } ebt_taps_s;

    typedef struct packed {
        logic rise;
        logic fall;
    } ebt_edges_s;

endpackage

// >>> hw/ebt_prescaler.sv
// free running prescaler producing one-cycle tap pulses
`timescale 1ns/1ps
module ebt_prescaler
    import ebt_pkg::*;
#(
    parameter int unsigned PRE_W = EBT_PRE_W
)
(
    input wire logic clk,
    input wire logic rst_n,
    output ebt_pkg::ebt_taps_s taps
);
    logic [PRE_W-1:0] pre_q;
    logic [PRE_W-1:0] pre_d;

    function automatic logic tap_hit(input logic [PRE_W-1:0] v, input int unsigned div);
        logic [PRE_W-1:0] m;
        m = PRE_W'(div - 1);
        tap_hit = ((v & m) == m);
    endfunction

    // never affected by the timer's source select, so a first prescaled tick lands 1..N clocks out
    always_comb
    begin
        pre_d = pre_q + PRE_W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pre_q <= '0;
        else
            pre_q <= pre_d;
    end

    always_comb
    begin
        taps.div8 = tap_hit(pre_q, EBT_DIV_A);
        taps.div64 = tap_hit(pre_q, EBT_DIV_B);
        taps.div256 = tap_hit(pre_q, EBT_DIV_C);
        taps.div1024 = tap_hit(pre_q, EBT_DIV_D);
    end
endmodule // ebt_prescaler

// >>> hw/ebt_pin_sync.sv
// two-flop sampler and edge detector for the external count pin
`timescale 1ns/1ps
module ebt_pin_sync
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_in,
    output ebt_pkg::ebt_edges_s edges
);
    import ebt_pkg::*;
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic [2:0] chain_d;

    always_comb
    begin
        chain_d = {pin_in, meta_q, sync_q};
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= chain_d[2];
            sync_q <= chain_d[1];
            prev_q <= chain_d[0];
        end
    end

    // only the second stage and its delayed copy feed the compare
    always_comb
    begin
        edges.rise = sync_q & ~prev_q;
        edges.fall = ~sync_q & prev_q;
    end
endmodule // ebt_pin_sync

// >>> hw/ebt_timer.sv
// 8-bit wrap timer with selectable tick source, apb register slave and wrap interrupt
`timescale 1ns/1ps
// Summary of operation
// - each timer tick adds one to the 8-bit count; no tick, no change
// - source zero stops the count; source one ticks every clock
// - sources two to five tick from prescaler taps 8, 64, 256, 1024
// - source six ticks on each falling edge of the count pin
// - source seven ticks on each rising edge of the count pin
// - pin edges count even while that pin is driven as an output
// - software may read and write the count at any time
// - a software count write beats a same-cycle increment
// - count only goes up, never cleared by hardware, wraps 0xff to 0x00
// - wrap flag sets in the same tick the count becomes zero
// - counting only sets the wrap flag, never clears it
// - wrap flag clears when the processor takes the wrap interrupt
// - wrap request needs enable bit 0, global enable and the flag
// - source select sits in control bits 2 down to 0
// - writing one to the wrap flag clears it; zero leaves it
// - prescaler runs free, independent of source select
// - count pin sampled every clock, then edge detected
module ebt_timer
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ebt_pkg::EBT_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ebt_pkg::EBT_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [ebt_pkg::EBT_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_pin,
    input wire logic wrap_irq_ack,
    output logic irq
);
    import ebt_pkg::*;

    logic [EBT_CNT_W-1:0] cnt_q;
    logic [EBT_CNT_W-1:0] cnt_d;
    logic [EBT_SEL_W-1:0] sel_q;
    logic [EBT_SEL_W-1:0] sel_d;
    logic ena_q;
    logic ena_d;
    logic flag_q;
    logic flag_d;
    logic gie_q;
    logic gie_d;
    logic [EBT_DATA_W-1:0] rdata_q;
    logic [EBT_DATA_W-1:0] rdata_d;
    logic err_q;
    logic err_d;

    ebt_taps_s taps;
    ebt_edges_s edges;
    logic timer_tick;
    logic wrap;
    logic acc;
    logic wr;
    logic rd;
    logic hit;
    logic lane0;
    logic ack_wr;

    // prescaler kept shared-style: no reset path from this timer's select
    ebt_prescaler #(
        .PRE_W(EBT_PRE_W)
    ) u_pre (
        .clk(clk),
        .rst_n(rst_n),
        .taps(taps)
    );

    // pin is an input here whatever its pad direction, so driven levels count too
    ebt_pin_sync u_pin (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(external_count_pin),
        .edges(edges)
    );

    function automatic logic addr_is(input logic [EBT_ADDR_W-1:0] a, input logic [11:0] ofs);
        addr_is = (a == ofs);
    endfunction

    // tick selection
    always_comb
    begin
        case (ebt_src_e'(sel_q))
            EBT_SRC_STOP: timer_tick = 1'b0;
            EBT_SRC_DIRECT: timer_tick = 1'b1;
            EBT_SRC_DIV8: timer_tick = taps.div8;
            EBT_SRC_DIV64: timer_tick = taps.div64;
            EBT_SRC_DIV256: timer_tick = taps.div256;
            EBT_SRC_DIV1024: timer_tick = taps.div1024;
            EBT_SRC_PIN_FALL: timer_tick = edges.fall;
            EBT_SRC_PIN_RISE: timer_tick = edges.rise;
            default: timer_tick = 1'b0;
        endcase
    end

    // apb decode: zero wait states, write lands at the access edge
    always_comb
    begin
        acc = psel & penable;
        wr = acc & pwrite;
        rd = acc & ~pwrite;
        lane0 = pstrb[0];
        hit = addr_is(paddr, EBT_OFS_CONTROL) | addr_is(paddr, EBT_OFS_COUNT)
            | addr_is(paddr, EBT_OFS_IRQ_MASK) | addr_is(paddr, EBT_OFS_IRQ_FLAGS)
            | addr_is(paddr, EBT_OFS_IRQ_STATUS) | addr_is(paddr, EBT_OFS_GLOBAL);
        pready = 1'b1;
        pslverr = err_q;
        prdata = rdata_q;
    end

    // counter and flag next state
    always_comb
    begin
        wrap = timer_tick & (cnt_q == EBT_CNT_MAX);
        cnt_d = cnt_q;
        if (timer_tick)
            cnt_d = cnt_q + EBT_CNT_ONE;
        if (wr && lane0 && addr_is(paddr, EBT_OFS_COUNT))
            cnt_d = pwdata[EBT_CNT_W-1:0];

        sel_d = sel_q;
        ena_d = ena_q;
        gie_d = gie_q;
        ack_wr = 1'b0;
        if (wr && lane0 && addr_is(paddr, EBT_OFS_CONTROL))
            sel_d = pwdata[EBT_SEL_LSB +: EBT_SEL_W];
        if (wr && lane0 && addr_is(paddr, EBT_OFS_IRQ_MASK))
            ena_d = pwdata[EBT_WRAP_BIT];
        if (wr && lane0 && addr_is(paddr, EBT_OFS_GLOBAL))
        begin
            gie_d = pwdata[EBT_GIE_BIT];
            ack_wr = pwdata[EBT_ACK_BIT];
        end

        // clears first, so a wrap in the same cycle wins
        flag_d = flag_q;
        if (wr && lane0 && addr_is(paddr, EBT_OFS_IRQ_FLAGS) && pwdata[EBT_WRAP_BIT])
            flag_d = 1'b0;
        if (rd && addr_is(paddr, EBT_OFS_IRQ_STATUS))
            flag_d = 1'b0;
        if (wrap_irq_ack || ack_wr)
            flag_d = 1'b0;
        if (wrap)
            flag_d = 1'b1;
    end

    // read data and error, registered at the access edge
    always_comb
    begin
        rdata_d = rdata_q;
        err_d = 1'b0;
        if (acc && !hit)
            err_d = 1'b1;
        if (rd)
        begin
            rdata_d = '0;
            if (addr_is(paddr, EBT_OFS_CONTROL))
                rdata_d[EBT_SEL_LSB +: EBT_SEL_W] = sel_q;
            else if (addr_is(paddr, EBT_OFS_COUNT))
                rdata_d[EBT_CNT_W-1:0] = cnt_q;
            else if (addr_is(paddr, EBT_OFS_IRQ_MASK))
                rdata_d[EBT_WRAP_BIT] = ena_q;
            else if (addr_is(paddr, EBT_OFS_IRQ_FLAGS) || addr_is(paddr, EBT_OFS_IRQ_STATUS))
                rdata_d[EBT_WRAP_BIT] = flag_q;
            else if (addr_is(paddr, EBT_OFS_GLOBAL))
                rdata_d[EBT_GIE_BIT] = gie_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= EBT_CNT_RST;
            sel_q <= EBT_SEL_RST;
            ena_q <= 1'b0;
            flag_q <= 1'b0;
            gie_q <= 1'b0;
            rdata_q <= '0;
            err_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            sel_q <= sel_d;
            ena_q <= ena_d;
            flag_q <= flag_d;
            gie_q <= gie_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // the data flop loads only at a read's access edge, so prdata holds that read's data until the next read
    always_comb
    begin
        irq = ena_q & gie_q & flag_q;
    end
endmodule // ebt_timer

// >>> sim/ebt_timer_checker.sv
// port level assertions for the 8-bit wrap timer
`timescale 1ns/1ps
module ebt_timer_checker
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ebt_pkg::EBT_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ebt_pkg::EBT_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wrap_irq_ack,
    input wire logic irq
);
    import ebt_pkg::*;
    logic acc;
    assign acc = psel && penable;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (acc && paddr > EBT_OFS_GLOBAL |=> pslverr) else $error("no slverr");
    a_err_mapped: assert property (acc && paddr == EBT_OFS_COUNT |=> !pslverr) else $error("bad slverr");
    a_err_pulse: assert property (pslverr && !acc |=> !pslverr) else $error("slverr stuck");
    a_irq_reset: assert property ($rose(rst_n) |-> !irq) else $error("irq after reset");
    a_irq_sticky: assert property (irq && !psel && !wrap_irq_ack |=> irq) else $error("irq dropped");
    a_rdata_upper: assert property (prdata[31:8] == 24'h000000) else $error("upper bits set");
    a_rdata_hold: assert property (!$past(acc && !pwrite) |-> $stable(prdata)) else $error("prdata moved");
    c_irq: cover property (irq);
    c_err: cover property (pslverr);
    c_ack: cover property (irq && wrap_irq_ack);
endmodule // ebt_timer_checker

// >>> sim/tb_ebt_timer.sv
// self-checking bench for the 8-bit wrap timer
`timescale 1ns/1ps
module tb_ebt_timer;
    import ebt_pkg::*;
    localparam logic [11:0] ctl = EBT_OFS_CONTROL;
    localparam logic [11:0] cnt = EBT_OFS_COUNT;
    localparam logic [11:0] msk = EBT_OFS_IRQ_MASK;
    localparam logic [11:0] flg = EBT_OFS_IRQ_FLAGS;
    localparam logic [11:0] sts = EBT_OFS_IRQ_STATUS;
    localparam logic [11:0] gie = EBT_OFS_GLOBAL;
    logic clk = 1'b0;
    logic rst_n, psel, penable, pwrite, pin, ack, pready, pslverr, irq, rd_v;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [3:0] pstrb;
    logic [7:0] d;
    logic err_v = 1'b0;
    logic err_e = 1'b0;
    logic [7:0] exp_q[$];
    int fails, checked;
    int unsigned dv[4] = '{EBT_DIV_A, EBT_DIV_B, EBT_DIV_C, EBT_DIV_D};
    always #2 clk = ~clk;
    ebt_timer u_dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_pin(pin), .wrap_irq_ack(ack), .irq(irq));
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task close_out;
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // a read notes its expected byte; the monitor compares it once prdata lands
    task apb(input logic [11:0] a, input logic [7:0] v, input logic w);
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h000000, v};
        if (!w)
            exp_q.push_back(v);
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk_irq(input logic e);
        @(posedge clk);
        chk("irq", {7'h00, e}, {7'h00, irq});
    endtask
    // prdata is registered at the access edge, so it is judged one edge later
    always @(posedge clk)
    begin
        if (rd_v)
            chk("prdata", exp_q.pop_front(), prdata[7:0]);
        rd_v <= psel && penable && !pwrite && pready;
        // pslverr is registered at the access edge, so it is judged one edge later too
        if (err_v)
            chk("pslverr", {7'h00, err_e}, {7'h00, pslverr});
        err_v <= psel && penable && pready;
        err_e <= !(paddr inside {ctl, cnt, msk, flg, sts, gie});
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end
    initial
    begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h00000000; pstrb = 4'hf; pin = 1'b1; ack = 1'b0; rd_v = 1'b0;
        seed = 32'h00014dd6;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        apb(ctl, 8'h00, 1'b0);
        apb(cnt, 8'h00, 1'b0);
        apb(msk, 8'h00, 1'b0);
        apb(flg, 8'h00, 1'b0);
        d = 8'(xs());
        apb(cnt, d, 1'b1);
        apb(cnt, d, 1'b0);
        apb(12'h020, 8'hff, 1'b1);
        apb(ctl, 8'h00, 1'b0);
        // three clock edges with source one: fd wraps to zero
        apb(cnt, 8'hfd, 1'b1);
        apb(ctl, 8'h01, 1'b1);
        apb(ctl, 8'h00, 1'b1);
        apb(cnt, 8'h00, 1'b0);
        apb(ctl, 8'h01, 1'b1);
        apb(cnt, 8'h40, 1'b1);
        apb(ctl, 8'h00, 1'b1);
        apb(cnt, 8'h43, 1'b0);
        apb(flg, 8'h00, 1'b1);
        apb(flg, 8'h01, 1'b0);
        apb(msk, 8'h01, 1'b1);
        apb(gie, 8'h01, 1'b1);
        chk_irq(1'b1);
        apb(msk, 8'h00, 1'b1);
        chk_irq(1'b0);
        apb(msk, 8'h01, 1'b1);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        chk_irq(1'b0);
        apb(flg, 8'h00, 1'b0);
        // a window of exactly two tap periods holds two ticks whatever the phase
        for (int i = 2; i < 6; i++)
        begin
            apb(cnt, 8'h00, 1'b1);
            apb(ctl, i[7:0], 1'b1);
            repeat (2 * dv[i-2] - 3) @(posedge clk);
            apb(ctl, 8'h00, 1'b1);
            apb(cnt, 8'h02, 1'b0);
        end
        for (int m = 6; m < 8; m++)
        begin
            apb(cnt, 8'hfd, 1'b1);
            apb(ctl, m[7:0], 1'b1);
            repeat (5)
            begin
                pin <= 1'b0;
                repeat (2 + xs() % 4) @(posedge clk);
                pin <= 1'b1;
                repeat (2 + xs() % 4) @(posedge clk);
            end
            repeat (4) @(posedge clk);
            apb(ctl, 8'h00, 1'b1);
            apb(cnt, 8'h02, 1'b0);
        end
        apb(sts, 8'h01, 1'b0);
        apb(sts, 8'h00, 1'b0);
        apb(flg, 8'h01, 1'b1);
        apb(flg, 8'h00, 1'b0);
        repeat (3) @(posedge clk);
        close_out();
    end
endmodule // tb_ebt_timer
bind ebt_timer ebt_timer_checker u_chk (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wrap_irq_ack(wrap_irq_ack), .irq(irq));
